/* File: wdtslp_consts.svh */
// Constants for the watchdog and sleep/wake control block
`ifndef WDTSLP_CONSTS_SVH
`define WDTSLP_CONSTS_SVH
// Register indices; byte address is four times the index
`define WS_IDX_OPTION 16'h0081
`define WS_IDX_CONFIG 16'h2007
`define WS_IDX_STATUS 16'h0000
`define WS_IDX_IRQCTL 16'h0001
`define WS_IDX_WAKEEN 16'h0002
// Option register fields and reset value
`define WS_OPTION_RST 8'hff
`define WS_OPT_PSA 3
`define WS_OPT_PS_HI 2
// Configuration word fields
`define WS_CFG_WATCHDOG_ENABLE_FUSE 2
`define WS_CFG_FOSC_HI 1
`define WS_FOSC_RC 2'h3
// Status register fields
`define WS_STAT_TO 4
`define WS_STAT_PD 3
`define WS_STAT_ASLEEP 0
// Global interrupt enable position in the interrupt control register
`define WS_IRQ_GIE 7
// Oscillator start-up wait, in main oscillator periods, and the periods
`define WS_OST_TOSC 1024
`define WS_TOSC_NS 40
`define WS_CLK_NS 40
`endif

/* File: wdtslp_pkg.sv */
// Types shared by the watchdog and sleep/wake control block
package wdtslp_pkg;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_OST = 2'b10
	} wdtslp_state_e;
endpackage

/* File: wdtslp_wdt_base.sv */
// Watchdog RC oscillator model and base time-out counter
`timescale 1ns/1ns
`default_nettype none
module wdtslp_wdt_base #(
	parameter int OSC_DIV = 4,
	parameter int BASE_CYCLES = 1024
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_run,
	input wire logic i_clear,
	output logic o_tick
);
	logic [15:0] div_q;
	logic [15:0] cnt_q;
	logic osc_tick;

	// Free-running divider stands for the private RC oscillator; never gated by sleep
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || div_q == 16'(OSC_DIV - 1)) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end
	assign osc_tick = (div_q == 16'(OSC_DIV - 1));

	// Base period counter, counted in oscillator cycles
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_clear || !i_run) begin
			cnt_q <= 16'h0000;
			o_tick <= 1'b0;
		end else if (osc_tick) begin
			o_tick <= (cnt_q == 16'(BASE_CYCLES - 1));
			cnt_q <= (cnt_q == 16'(BASE_CYCLES - 1)) ? 16'h0000 : cnt_q + 16'h0001;
		end else begin
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: wdtslp_prescaler.sv */
// Shared prescaler: timer-zero prescaler or watchdog postscaler
`timescale 1ns/1ns
`default_nettype none
module wdtslp_prescaler (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_clear,
	input wire logic i_sel_wdt,
	input wire logic [2:0] i_ratio,
	input wire logic i_wdt_tick,
	input wire logic i_tmr0_tick,
	output logic o_wdt_timeout,
	output logic o_tmr0_inc
);
	logic [7:0] cnt_q;
	logic evt;
	logic hit;

	// Mask of low count bits that must all be set before a pulse passes
	function automatic logic [7:0] ratio_mask(input logic sel_wdt, input logic [2:0] r);
		logic [3:0] n;
		n = sel_wdt ? {1'b0, r} : {1'b0, r} + 4'h1;
		ratio_mask = 8'((9'h001 << n) - 9'h001);
	endfunction

	assign evt = i_sel_wdt ? i_wdt_tick : i_tmr0_tick;
	assign hit = evt && ((cnt_q & ratio_mask(i_sel_wdt, i_ratio)) == ratio_mask(i_sel_wdt, i_ratio));

	// Count only the events of whichever side owns the prescaler
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_clear) begin
			cnt_q <= 8'h00;
		end else if (evt) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// The side without the prescaler sees its raw events at one to one
	assign o_wdt_timeout = i_sel_wdt ? hit : i_wdt_tick;
	assign o_tmr0_inc = i_sel_wdt ? i_tmr0_tick : hit;
endmodule
`default_nettype wire

/* File: wdtslp_top.sv */
// Watchdog timer with sleep entry and wake-up control, AHB-Lite registers
//
// Behaviour
// - Watchdog ticks from its own free-running oscillator, unaffected by sleep.
// - Watchdog time-out while running issues a full device reset.
// - Watchdog time-out while asleep wakes the device and resumes execution.
// - Any watchdog time-out clears the active-low time-out flag.
// - Watchdog enable fuse cleared keeps the watchdog permanently off.
// - One prescaler serves timer zero or watchdog, set by option register.
// - Kick or sleep clears watchdog and postscaler when assigned to it.
// - Kick clears the prescaler count only when assigned to the watchdog, and never its assignment.
// - Sleep clears watchdog, clears power-down flag, sets time-out flag, stops oscillator.
// - I/O ports hold their pre-sleep state while asleep.
// - Master clear resets; watchdog or interrupt wake continues execution.
// - Power-down flag set at power-up, cleared by each executed sleep.
// - Only clockless peripheral interrupts are wired as wake sources.
// - Sleep prefetches the instruction at the next program address.
// - Interrupt wakes only with its own enable set, ignoring global enable.
// - After interrupt wake, vector follows the next instruction only with global enable.
// - Sleep with an enabled interrupt already pending acts as a no-op.
// - Interrupt during or after sleep completes sleep, then wakes at once.
// - Wake waits 1024 oscillator periods, except in RC oscillator mode.
// - Global interrupt enable is bit seven of the interrupt control register.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "wdtslp_consts.svh"
module wdtslp_top import wdtslp_pkg::*; #(
	parameter int NUM_WAKE = 9,
	parameter int WDT_OSC_DIV = 4,
	parameter int WDT_BASE_CYCLES = 1024
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic [7:0] i_config_word,
	input wire logic i_master_clear_n,
	input wire logic i_kick_instr,
	input wire logic i_sleep_instr,
	input wire logic [12:0] i_pc,
	input wire logic [NUM_WAKE-1:0] i_wake_flags,
	input wire logic i_tmr0_tick,
	output logic o_device_reset,
	output logic o_osc_run,
	output logic o_io_hold,
	output logic [12:0] o_prefetch_pc,
	output logic o_resume,
	output logic o_irq_vector,
	output logic o_tmr0_inc,
	output logic o_timeout_flag_n,
	output logic o_powerdown_flag_n
);
	localparam int OST_CYCLES = `WS_OST_TOSC * `WS_TOSC_NS / `WS_CLK_NS;

	wdtslp_state_e state_q;
	logic [7:0] option_q;
	logic [7:0] cfg_q;
	logic [7:0] irqctl_q;
	logic [NUM_WAKE-1:0] wake_en_q;
	logic [NUM_WAKE-1:0] wake_m_q;
	logic [NUM_WAKE-1:0] wake_s_q;
	logic master_clear_n_m_q;
	logic master_clear_n_s_q;
	logic wr_q;
	logic [15:0] widx_q;
	logic [10:0] ost_cnt_q;
	logic wake_irq_q;
	logic base_tick;
	logic scaled_to;
	logic tmr0_inc;
	logic wdt_en;
	logic wdt_to;
	logic pending;
	logic sleep_taken;
	logic wdt_clr;
	logic fosc_rc;
	logic wake_go;
	logic addr_ok;
	logic [15:0] aidx;

	// Register read mux, shared by the read path and nothing else duplicated
	function automatic logic [31:0] reg_read(input logic [15:0] idx);
		reg_read = 32'h0000_0000;
		if (idx == `WS_IDX_OPTION) begin
			reg_read[7:0] = option_q;
		end else if (idx == `WS_IDX_CONFIG) begin
			reg_read[7:0] = cfg_q;
		end else if (idx == `WS_IDX_STATUS) begin
			reg_read[`WS_STAT_TO] = o_timeout_flag_n;
			reg_read[`WS_STAT_PD] = o_powerdown_flag_n;
			reg_read[`WS_STAT_ASLEEP] = (state_q != ST_RUN);
		end else if (idx == `WS_IDX_IRQCTL) begin
			reg_read[7:0] = irqctl_q;
		end else if (idx == `WS_IDX_WAKEEN) begin
			reg_read[NUM_WAKE-1:0] = wake_en_q;
		end
	endfunction

	// Pins and clockless peripheral flags arrive asynchronously: two flops each
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			master_clear_n_m_q <= 1'b1;
			master_clear_n_s_q <= 1'b1;
			wake_m_q <= '0;
			wake_s_q <= '0;
		end else begin
			master_clear_n_m_q <= i_master_clear_n;
			master_clear_n_s_q <= master_clear_n_m_q;
			wake_m_q <= i_wake_flags;
			wake_s_q <= wake_m_q;
		end
	end

	// Fuses are sampled while reset is held, so they settle before use
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cfg_q <= i_config_word;
		end
	end

	assign wdt_en = cfg_q[`WS_CFG_WATCHDOG_ENABLE_FUSE];
	assign fosc_rc = (cfg_q[`WS_CFG_FOSC_HI -: 2] == `WS_FOSC_RC);
	// Individual enables alone decide wake; global enable is not consulted
	assign pending = |(wake_s_q & wake_en_q);
	assign sleep_taken = (state_q == ST_RUN) && i_sleep_instr && !pending;
	assign wdt_clr = i_kick_instr || sleep_taken || !wdt_en;
	assign wdt_to = wdt_en && scaled_to;

	// Base counter runs on its own oscillator tick in every state
	wdtslp_wdt_base #(
		.OSC_DIV(WDT_OSC_DIV),
		.BASE_CYCLES(WDT_BASE_CYCLES)
	) u_base (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_run(wdt_en),
		.i_clear(wdt_clr),
		.o_tick(base_tick)
	);

	// Postscaler is cleared only when the watchdog owns it; option bits untouched
	wdtslp_prescaler u_presc (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_clear(wdt_clr && option_q[`WS_OPT_PSA]),
		.i_sel_wdt(option_q[`WS_OPT_PSA]),
		.i_ratio(option_q[`WS_OPT_PS_HI -: 3]),
		.i_wdt_tick(base_tick),
		.i_tmr0_tick(i_tmr0_tick),
		.o_wdt_timeout(scaled_to),
		.o_tmr0_inc(tmr0_inc)
	);

	// AHB-Lite: zero wait states, always OKAY
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign aidx = i_haddr[17:2];
	assign addr_ok = (i_haddr[31:18] == 14'h0000) && (i_haddr[1:0] == 2'h0);

	// Address phase latches writes and looks up read data for the data phase
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wr_q <= 1'b0;
			widx_q <= 16'h0000;
			o_hrdata <= 32'h0000_0000;
		end else if (i_hready) begin
			wr_q <= i_hsel && i_htrans[1] && i_hwrite && addr_ok;
			widx_q <= aidx;
			if (i_hsel && i_htrans[1] && !i_hwrite && addr_ok) begin
				o_hrdata <= reg_read(aidx);
			end else begin
				o_hrdata <= 32'h0000_0000;
			end
		end
	end

	// Data phase writes; the assignment bit changes only by a bus write
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			option_q <= `WS_OPTION_RST;
			irqctl_q <= 8'h00;
			wake_en_q <= '0;
		end else if (wr_q) begin
			if (widx_q == `WS_IDX_OPTION) begin
				option_q <= i_hwdata[7:0];
			end else if (widx_q == `WS_IDX_IRQCTL) begin
				irqctl_q <= i_hwdata[7:0];
			end else if (widx_q == `WS_IDX_WAKEEN) begin
				wake_en_q <= i_hwdata[NUM_WAKE-1:0];
			end
		end
	end

	// A wake is a watchdog time-out or an enabled interrupt while asleep
	assign wake_go = (state_q == ST_SLEEP) && master_clear_n_s_q && (wdt_to || pending);

	// Power state: run, asleep with oscillator off, start-up wait
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_RUN;
			ost_cnt_q <= 11'h000;
			wake_irq_q <= 1'b0;
		end else begin
			case (state_q)
				ST_RUN: begin
					ost_cnt_q <= 11'h000;
					if (sleep_taken && master_clear_n_s_q) begin
						state_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (!master_clear_n_s_q) begin
						state_q <= ST_RUN;
					end else if (wake_go) begin
						wake_irq_q <= pending && !wdt_to;
						state_q <= fosc_rc ? ST_RUN : ST_OST;
					end
				end
				ST_OST: begin
					// RC mode skips this wait; the crystal needs time to settle
					if (!master_clear_n_s_q) begin
						state_q <= ST_RUN;
					end else if (ost_cnt_q == 11'(OST_CYCLES - 1)) begin
						state_q <= ST_RUN;
					end else begin
						ost_cnt_q <= ost_cnt_q + 11'h001;
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// Resume pulse and interrupt vector request at the return to run
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_resume <= 1'b0;
			o_irq_vector <= 1'b0;
		end else begin
			o_resume <= master_clear_n_s_q && ((wake_go && fosc_rc) ||
				(state_q == ST_OST && ost_cnt_q == 11'(OST_CYCLES - 1)));
			// The core runs the prefetched instruction, then branches on this
			o_irq_vector <= irqctl_q[`WS_IRQ_GIE] && master_clear_n_s_q &&
				((wake_go && fosc_rc && pending && !wdt_to) ||
				(state_q == ST_OST && ost_cnt_q == 11'(OST_CYCLES - 1) && wake_irq_q));
		end
	end

	// Reset request: watchdog while running, or master clear at any time
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_device_reset <= 1'b0;
		end else begin
			o_device_reset <= (wdt_to && state_q == ST_RUN) || !master_clear_n_s_q;
		end
	end

	// Status flags; the time-out event wins over a same-cycle kick or sleep
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_timeout_flag_n <= 1'b1;
			o_powerdown_flag_n <= 1'b1;
		end else begin
			if (i_kick_instr && state_q == ST_RUN) begin
				o_timeout_flag_n <= 1'b1;
				o_powerdown_flag_n <= 1'b1;
			end
			if (sleep_taken) begin
				o_timeout_flag_n <= 1'b1;
				o_powerdown_flag_n <= 1'b0;
			end
			if (wdt_to) begin
				o_timeout_flag_n <= 1'b0;
			end
		end
	end

	// Prefetch address and registered timer-zero increment
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_prefetch_pc <= 13'h0000;
			o_tmr0_inc <= 1'b0;
		end else begin
			if (i_sleep_instr) begin
				o_prefetch_pc <= i_pc + 13'h0001;
			end
			o_tmr0_inc <= tmr0_inc;
		end
	end

	// Oscillator driver off and ports frozen from sleep until the wait ends
	assign o_osc_run = (state_q == ST_RUN);
	assign o_io_hold = (state_q != ST_RUN);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// A same-cycle time-out keeps the time-out flag low, so it is left out here
	sequence s_sleep_enter;
		sleep_taken && master_clear_n_s_q && !wdt_to;
	endsequence
	sequence s_asleep_done;
		!o_powerdown_flag_n && o_timeout_flag_n && !o_osc_run;
	endsequence

	a_reset_on_to: assert property (state_q == ST_RUN && wdt_to |=> o_device_reset)
		else $error("watchdog time-out in run gave no reset");
	a_wake_on_to: assert property (state_q == ST_SLEEP && wdt_to && master_clear_n_s_q |=>
		state_q != ST_SLEEP && !o_device_reset)
		else $error("watchdog time-out in sleep did not wake");
	a_to_flag_clr: assert property (wdt_to |=> !o_timeout_flag_n)
		else $error("time-out flag not cleared");
	a_wdt_disabled: assert property (!wdt_en |-> !wdt_to ##1 !o_device_reset || !master_clear_n_s_q)
		else $error("disabled watchdog timed out");
	a_sleep_entry: assert property (s_sleep_enter |=> s_asleep_done)
		else $error("sleep entry left flags or oscillator wrong");
	a_sleep_nop: assert property (state_q == ST_RUN && i_sleep_instr && pending
		|=> state_q == ST_RUN && $stable(o_powerdown_flag_n))
		else $error("sleep with pending interrupt was not a no-op");
	a_ost_wait: assert property (disable iff (i_sys_rst || !master_clear_n_s_q)
		$rose(state_q == ST_OST) |-> (state_q == ST_OST)[*8])
		else $error("start-up wait ended early");
	a_rc_no_wait: assert property (wake_go && fosc_rc |=> o_resume && o_osc_run)
		else $error("RC mode wake was delayed");
	a_vector_gie: assert property (o_irq_vector |-> o_resume && $past(irqctl_q[`WS_IRQ_GIE]))
		else $error("vector without global enable");
	a_prefetch_next: assert property (i_sleep_instr |=> o_prefetch_pc == $past(i_pc) + 13'h0001)
		else $error("prefetch address not next");
	a_hold_ports: assert property (state_q == ST_SLEEP |-> o_io_hold && !o_osc_run)
		else $error("ports not held in sleep");
endmodule
`default_nettype wire

/* File: watchdog_sleep_wake_control_tb.sv */
// Self-checking bench for the watchdog and sleep/wake control block
`timescale 1ns/1ns
`default_nettype none
`include "wdtslp_consts.svh"
module watchdog_sleep_wake_control_tb;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, master_clear_n_n = 1, kick = 0, slp = 0, t0 = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] cfg = 0;
	logic [12:0] pc = 0, p;
	logic [8:0] wk = 0;
	logic hro, hresp, dres, oscr, ioh, res, vec, t0inc, ton, pdn;
	logic [31:0] hrdata;
	logic [12:0] ppc;
	int bad_count = 0, checks_done = 0, seed = 39, n, cyc = 0, rcount = 0, r0, b, r;
	// Byte addresses are four times the register index
	localparam logic [31:0] A_OPT = 32'({`WS_IDX_OPTION, 2'b00});
	localparam logic [31:0] A_CFG = 32'({`WS_IDX_CONFIG, 2'b00});
	localparam logic [31:0] A_IRQ = 32'h0000_0004;
	localparam logic [31:0] A_WEN = 32'h0000_0008;
	// Small watchdog counts keep the run short: base time-out is 32 cycles
	wdtslp_top #(.WDT_OSC_DIV(2), .WDT_BASE_CYCLES(16)) dut (
		.i_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hro),
		.o_hreadyout(hro), .o_hresp(hresp), .o_hrdata(hrdata), .i_config_word(cfg),
		.i_master_clear_n(master_clear_n_n), .i_kick_instr(kick), .i_sleep_instr(slp), .i_pc(pc),
		.i_wake_flags(wk), .i_tmr0_tick(t0), .o_device_reset(dres), .o_osc_run(oscr),
		.o_io_hold(ioh), .o_prefetch_pc(ppc), .o_resume(res), .o_irq_vector(vec),
		.o_tmr0_inc(t0inc), .o_timeout_flag_n(ton), .o_powerdown_flag_n(pdn));
	// Clock of 40 ns
	initial begin
		forever #20 clk = ~clk;
	end
	// Cycle count, reset pulse count and hang guard
	always @(posedge clk) begin
		cyc++;
		if (dres === 1'b1) rcount++;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	task finish_test();
		if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Prefetch address wraps within the 13-bit program counter
	function automatic logic [12:0] next_pc(input logic [12:0] a);
		return a + 13'h0001;
	endfunction
	// Timer-zero increments over 64 events at ratio 1:2^(rr+1)
	function automatic int tmr0_expect(input int rr);
		return 64 >> (rr + 1);
	endfunction
	// One single word transfer; waits on hready, never on a fixed count
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (hro !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= d;
		@(posedge clk);
		while (hro !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task rst_dut(input logic [7:0] c);
		rst <= 1;
		cfg <= c;
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
	endtask
	task pulse(input int s);
		p = 13'($random(seed));
		pc <= p;
		if (s) slp <= 1;
		else kick <= 1;
		@(posedge clk);
		slp <= 0;
		kick <= 0;
		#1;
	endtask
	// Bounded wait on resume (s=1) or device reset (s=0), counting cycles
	task wt(input int s, output int k);
		k = 0;
		while ((s ? res : dres) !== 1'b1 && k < 3000) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask
	initial begin
		// Fuse off, crystal mode: interrupt wakes with start-up wait
		rst_dut(8'h30);
		#1;
		check("ton", ton, 1);
		check("pdn", pdn, 1);
		check("oscr", oscr, 1);
		ahb(0, A_OPT, 0);
		check("opt rst", rd, 32'h0000_00ff);
		check("hresp", hresp, 0);
		ahb(1, A_CFG, 32'h0000_00ff);
		ahb(0, A_CFG, 0);
		check("cfg ro", rd, 32'h0000_0030);
		ahb(0, 32'h0000_0100, 0);
		check("unmapped", rd, 0);
		ahb(1, A_OPT, 0);
		ahb(0, A_OPT, 0);
		check("opt rw", rd, 0);
		b = {$random(seed)} % 9;
		ahb(1, A_WEN, 32'(1 << b));
		ahb(1, A_IRQ, 32'h0000_0080);
		ahb(0, A_IRQ, 0);
		check("gie", rd, 32'h0000_0080);
		// Enabled flag already pending: sleep does nothing
		wk <= 9'(1 << b);
		repeat (4) @(posedge clk);
		pulse(1);
		@(posedge clk);
		#1;
		check("noop pdn", pdn, 1);
		check("noop osc", oscr, 1);
		wk <= 0;
		repeat (4) @(posedge clk);
		pulse(1);
		check("slp osc", oscr, 0);
		check("slp hold", ioh, 1);
		check("slp pdn", pdn, 0);
		check("slp ton", ton, 1);
		check("prefetch", ppc, next_pc(p));
		ahb(0, 32'h0000_0000, 0);
		check("status", rd, 32'h0000_0011);
		// A flag whose enable is clear must not wake
		wk <= 9'(1 << ((b + 1) % 9));
		repeat (40) @(posedge clk);
		#1;
		check("masked", oscr, 0);
		wk <= 9'(1 << b);
		wt(1, n);
		check("ost", (n >= 1024 && n <= 1032), 1);
		check("vec gie", vec, 1);
		wk <= 0;
		ahb(1, A_IRQ, 0);
		repeat (4) @(posedge clk);
		pulse(1);
		wk <= 9'(1 << b);
		wt(1, n);
		check("wake no gie", res, 1);
		check("vec off", vec, 0);
		wk <= 0;
		check("fuse off", rcount, 0);
		// Master clear in sleep resets rather than resumes
		repeat (4) @(posedge clk);
		pulse(1);
		master_clear_n_n <= 0;
		repeat (4) @(posedge clk);
		#1;
		check("master_clear_n rst", dres, 1);
		check("master_clear_n osc", oscr, 1);
		master_clear_n_n <= 1;
		// Fuse on, RC mode: watchdog active, no start-up wait
		rst_dut(8'h07);
		ahb(1, A_OPT, 0);
		r0 = rcount;
		repeat (10) begin
			pulse(0);
			repeat (15) @(posedge clk);
		end
		check("kicked", rcount - r0, 0);
		pulse(0);
		wt(0, n);
		check("wdt run", (n >= 28 && n <= 36), 1);
		check("to run", ton, 0);
		ahb(1, A_OPT, 32'h0000_0009);
		pulse(0);
		ahb(0, A_OPT, 0);
		check("assign kept", rd, 32'h0000_0009);
		pulse(0);
		wt(0, n);
		check("postscale", (n >= 58 && n <= 70), 1);
		ahb(1, A_OPT, 0);
		// Kick ahead of sleep, as software is advised to do
		pulse(0);
		r0 = rcount;
		pulse(1);
		wt(1, n);
		check("wdt wake", (n >= 26 && n <= 40), 1);
		check("wake no rst", rcount - r0, 0);
		check("wake ton", ton, 0);
		check("wake vec", vec, 0);
		// Timer-zero prescale ratio, prescaler away from the watchdog
		r = {$random(seed)} % 4;
		ahb(1, A_OPT, 32'(r));
		n = 0;
		t0 <= 1;
		repeat (64) begin
			@(posedge clk);
			#1;
			if (t0inc === 1'b1) n++;
		end
		t0 <= 0;
		check("tmr0", (n >= tmr0_expect(r) - 1 && n <= tmr0_expect(r) + 1), 1);
		finish_test();
	end
endmodule
`default_nettype wire
